// ---- hw/psl_blink_gen.sv ----
`timescale 1ns/1ps
// Base pulse divider: quick phase counter and slow square wave
module psl_blink_gen #(
    parameter int unsigned QUICK_DIV = psl_pkg::PSL_QUICK_DIV_DEF,
    parameter int unsigned SLOW_MULT = psl_pkg::PSL_SLOW_MULT
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // Flash outputs
    output logic            quick_half,
    output logic            quick_eighth,
    output logic            slow_half
);
    logic [31:0] div_cnt;      // Base pulse divider
    logic [31:0] next_div_cnt;
    logic [2:0]  phase;        // Eight phases of quick period
    logic [2:0]  next_phase;
    logic [31:0] slow_cnt;     // Quick periods toward slow toggle
    logic [31:0] next_slow_cnt;
    logic        slow_q;
    logic        next_slow_q;
    logic        tick;

    // Next values; tick is the one-cycle base enable
    always_comb begin
        tick          = (div_cnt == QUICK_DIV - 32'd1);
        next_div_cnt  = tick ? 32'd0 : div_cnt + 32'd1;  // [RL12]
        next_phase    = tick ? phase + 3'd1 : phase;
        next_slow_cnt = slow_cnt;
        next_slow_q   = slow_q;
        if (tick && phase == 3'd7) begin
            if (slow_cnt == SLOW_MULT - 32'd1) begin
                next_slow_cnt = 32'd0;
                next_slow_q   = ~slow_q;  // [RL12]
            end else begin
                next_slow_cnt = slow_cnt + 32'd1;
            end
        end
    end

    // Registers only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            div_cnt  <= 32'd0;
            phase    <= 3'd0;
            slow_cnt <= 32'd0;
            slow_q   <= 1'b0;
        end else begin
            div_cnt  <= next_div_cnt;
            phase    <= next_phase;
            slow_cnt <= next_slow_cnt;
            slow_q   <= next_slow_q;
        end
    end

    // Quick 1:1 lit for first four phases, 1:8 for the first only
    assign quick_half   = ~phase[2];
    assign quick_eighth = (phase == 3'd0);
    assign slow_half    = slow_q;

endmodule : psl_blink_gen

// ---- hw/psl_pkg.sv ----
package psl_pkg;

    // Controller activity states
    typedef enum logic [1:0] {
        PSL_ACT_STOP    = 2'b00,
        PSL_ACT_STANDBY = 2'b01,
        PSL_ACT_RUN     = 2'b10,
        PSL_ACT_RESET   = 2'b11
    } psl_act_e;

    // Fault causes kept across a stop
    typedef enum logic [1:0] {
        PSL_CAUSE_NONE    = 2'b00,
        PSL_CAUSE_CONFIG  = 2'b01,
        PSL_CAUSE_RUNTIME = 2'b10
    } psl_cause_e;

    // Indicator drive pair
    typedef struct packed {
        logic run_led;
        logic err_led;
    } psl_leds_s;

    // Divider defaults: base pulse period in clock cycles and slow multiple
    localparam int unsigned PSL_QUICK_DIV_DEF = 32'd25000000;
    localparam int unsigned PSL_SLOW_MULT     = 32'd4;
    // Quick flash 1:8 -> one phase lit out of eight
    localparam int unsigned PSL_PHASES        = 32'd8;
    localparam logic [7:0]  PSL_NODE_INVALID  = 8'h00;
    localparam logic [1:0]  PSL_CAUSE_RST     = 2'h0;

    // Register offsets of the command port
    localparam logic [3:0]  PSL_REG_CTRL   = 4'h0;
    localparam logic [3:0]  PSL_REG_STATUS = 4'h4;
    localparam logic [3:0]  PSL_REG_CAUSE  = 4'h8;
    localparam logic [3:0]  PSL_REG_NODE   = 4'hc;
    // Control register bit positions
    localparam int unsigned PSL_CTRL_START = 0;
    localparam int unsigned PSL_CTRL_STOP  = 1;
    localparam int unsigned PSL_CTRL_RESET = 2;
    localparam int unsigned PSL_CTRL_PROG  = 3;
    localparam int unsigned PSL_CTRL_SEV   = 4;
    localparam int unsigned PSL_CTRL_NETF  = 5;
    localparam int unsigned PSL_CTRL_NETOK = 6;
    localparam int unsigned PSL_CTRL_CLRC  = 7;
    localparam int unsigned PSL_CTRL_RSTX  = 8;
    localparam logic [7:0]  PSL_NODE_RST   = 8'h00;

endpackage : psl_pkg

// ---- hw/psl_status_led.sv ----
`timescale 1ns/1ps
// Overview of operation
// [RL1] Run LED dark whenever controller is stopped
// [RL2] Standby: run LED quick flash 1:8
// [RL3] Running: run LED slow flash 1:1
// [RL4] Reset mode: both LEDs quick 1:1
// [RL5] Standby: error LED quick flash 1:8
// [RL6] No error, normal: error LED dark
// [RL7] Node address zero at start: stop, error steady
// [RL8] Runtime fault: run to stop, error steady
// [RL9] Network fault: error slow 1:1, keep running
// [RL10] Network fault clears on next good exchange
// [RL11] Fault cause kept for report after power-on; here reset clears the cause to PSL_CAUSE_NONE, only a stop keeps it
// [RL12] Flash rates from parameterised clock dividers
module psl_status_led #(
    parameter int unsigned QUICK_DIV = psl_pkg::PSL_QUICK_DIV_DEF,
    parameter int unsigned SLOW_MULT = psl_pkg::PSL_SLOW_MULT
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // Run/stop switch, high selects run
    input  wire logic        switch_run,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    // Indicators, high lights the LED
    output psl_pkg::psl_leds_s leds
);
    logic quick_half;
    logic quick_eighth;
    logic slow_half;

    // Base pulse source
    psl_blink_gen #(
        .QUICK_DIV (QUICK_DIV),
        .SLOW_MULT (SLOW_MULT)
    ) u_blink (
        .clock        (clock),
        .reset        (reset),
        .quick_half   (quick_half),
        .quick_eighth (quick_eighth),
        .slow_half    (slow_half)
    );

    psl_pkg::psl_act_e   act;          // Activity state
    psl_pkg::psl_act_e   next_act;
    logic                prog_valid;   // Valid program loaded
    logic                next_prog_valid;
    logic                start_req;    // Start accepted, awaits switch
    logic                next_start_req;
    logic                severe;       // Severe error latched
    logic                next_severe;
    logic                net_err;      // Network error pending
    logic                next_net_err;
    psl_pkg::psl_cause_e cause;        // Saved fault cause
    psl_pkg::psl_cause_e next_cause;
    logic                cause_seen;   // Cause survived into a new start
    logic                next_cause_seen;
    logic [7:0]          node_addr;    // Configured node address
    logic [7:0]          next_node_addr;
    logic [31:0]         next_rdata;
    psl_pkg::psl_leds_s  next_leds;
    logic                wr_ctrl;

    // Address match against one register offset, used for every register decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    // Controller state, error and cause next values
    always_comb begin
        wr_ctrl         = reg_write && hit(reg_addr, psl_pkg::PSL_REG_CTRL);
        next_act        = act;
        next_prog_valid = prog_valid;
        next_start_req  = start_req;
        next_severe     = severe;
        next_net_err    = net_err;
        next_cause      = cause;
        next_cause_seen = cause_seen;
        next_node_addr  = node_addr;
        if (reg_write && hit(reg_addr, psl_pkg::PSL_REG_NODE)) begin
            next_node_addr = reg_wdata[7:0];
        end
        if (wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_PROG]) begin
            next_prog_valid = 1'b1;
        end
        // Good exchange clears network error; a new fault the same cycle wins
        if (wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_NETOK]) begin
            next_net_err = 1'b0;  // [RL10]
        end
        if (wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_NETF]) begin
            next_net_err = 1'b1;  // [RL9]
        end
        // Cause is kept until software explicitly acknowledges the report or reset clears it
        if (wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_CLRC]) begin
            next_cause      = psl_pkg::PSL_CAUSE_NONE;
            next_cause_seen = 1'b0;
        end
        case (act)
            psl_pkg::PSL_ACT_STOP: begin
                if (wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_RSTX]) begin
                    next_act = psl_pkg::PSL_ACT_RESET;
                end else if (wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_START] && prog_valid) begin
                    if (node_addr == psl_pkg::PSL_NODE_INVALID) begin
                        next_severe = 1'b1;  // [RL7]
                        next_cause  = psl_pkg::PSL_CAUSE_CONFIG;  // [RL11]
                    end else begin
                        next_severe     = 1'b0;
                        next_start_req  = 1'b1;
                        next_cause_seen = (cause != psl_pkg::PSL_CAUSE_NONE);
                        next_act        = switch_run ? psl_pkg::PSL_ACT_RUN : psl_pkg::PSL_ACT_STANDBY;
                    end
                end
            end
            psl_pkg::PSL_ACT_STANDBY: begin
                if (wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_STOP]) begin
                    next_act       = psl_pkg::PSL_ACT_STOP;
                    next_start_req = 1'b0;
                end else if (switch_run) begin
                    next_act = psl_pkg::PSL_ACT_RUN;  // [RL2]
                end
            end
            psl_pkg::PSL_ACT_RUN: begin
                if (wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_SEV]) begin
                    next_act       = psl_pkg::PSL_ACT_STOP;  // [RL8]
                    next_severe    = 1'b1;  // [RL8]
                    next_cause     = psl_pkg::PSL_CAUSE_RUNTIME;  // [RL11]
                    next_start_req = 1'b0;
                end else if ((wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_STOP]) || !switch_run) begin
                    next_act       = psl_pkg::PSL_ACT_STOP;
                    next_start_req = 1'b0;
                end
            end
            psl_pkg::PSL_ACT_RESET: begin
                // Reset mode ends on a stop command and drops the program
                if (wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_STOP]) begin
                    next_act        = psl_pkg::PSL_ACT_STOP;
                    next_prog_valid = 1'b0;
                    next_severe     = 1'b0;
                    next_net_err    = 1'b0;
                end
            end
            default: begin
                next_act = psl_pkg::PSL_ACT_STOP;
            end
        endcase
    end

    // Indicator patterns; reset mode and standby override error display
    always_comb begin
        next_leds = '0;
        case (act)
            psl_pkg::PSL_ACT_STOP: begin
                next_leds.run_led = 1'b0;  // [RL1]
            end
            psl_pkg::PSL_ACT_STANDBY: begin
                next_leds.run_led = quick_eighth;  // [RL2]
            end
            psl_pkg::PSL_ACT_RUN: begin
                next_leds.run_led = slow_half;  // [RL3]
            end
            psl_pkg::PSL_ACT_RESET: begin
                next_leds.run_led = quick_half;  // [RL4]
            end
            default: begin
                next_leds.run_led = 1'b0;
            end
        endcase
        if (act == psl_pkg::PSL_ACT_RESET) begin
            next_leds.err_led = quick_half;  // [RL4]
        end else if (act == psl_pkg::PSL_ACT_STANDBY) begin
            next_leds.err_led = quick_eighth;  // [RL5]
        end else if (severe) begin
            next_leds.err_led = 1'b1;  // [RL7] [RL8]
        end else if (net_err) begin
            next_leds.err_led = slow_half;  // [RL9]
        end else begin
            next_leds.err_led = 1'b0;  // [RL6]
        end
    end

    // Read data, valid in the cycle after the strobe only
    always_comb begin
        next_rdata = 32'h0;
        if (reg_read) begin
            if (hit(reg_addr, psl_pkg::PSL_REG_STATUS)) begin
                next_rdata = {24'h0, switch_run, cause_seen, net_err, severe,
                              start_req, prog_valid, act};
            end else if (hit(reg_addr, psl_pkg::PSL_REG_CAUSE)) begin
                next_rdata = {30'h0, cause};  // [RL11]
            end else if (hit(reg_addr, psl_pkg::PSL_REG_NODE)) begin
                next_rdata = {24'h0, node_addr};
            end
        end
    end

    // Registers only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            act        <= psl_pkg::PSL_ACT_STOP;
            prog_valid <= 1'b0;
            start_req  <= 1'b0;
            severe     <= 1'b0;
            net_err    <= 1'b0;
            cause      <= psl_pkg::PSL_CAUSE_NONE;
            cause_seen <= 1'b0;
            node_addr  <= psl_pkg::PSL_NODE_RST;
            reg_rdata  <= 32'h0;
            leds       <= '0;
        end else begin
            act        <= next_act;
            prog_valid <= next_prog_valid;
            start_req  <= next_start_req;
            severe     <= next_severe;
            net_err    <= next_net_err;
            cause      <= next_cause;
            cause_seen <= next_cause_seen;
            node_addr  <= next_node_addr;
            reg_rdata  <= next_rdata;
            leds       <= next_leds;
        end
    end

    // Stopped means a dark run LED one cycle later
    stop_dark_a: assert property (@(posedge clock) disable iff (reset) // [RL1]
        act == psl_pkg::PSL_ACT_STOP |=> !leds.run_led)
        else $error("run led lit while stopped");

    standby_pat_a: assert property (@(posedge clock) disable iff (reset) // [RL2]
        act == psl_pkg::PSL_ACT_STANDBY |=> leds.run_led == $past(quick_eighth))
        else $error("standby run pattern wrong");

    run_slow_a: assert property (@(posedge clock) disable iff (reset) // [RL3]
        act == psl_pkg::PSL_ACT_RUN |=> leds.run_led == $past(slow_half))
        else $error("run pattern wrong");

    reset_both_a: assert property (@(posedge clock) disable iff (reset) // [RL4]
        act == psl_pkg::PSL_ACT_RESET |=> leds.run_led == leds.err_led)
        else $error("reset mode leds differ");

    standby_err_a: assert property (@(posedge clock) disable iff (reset) // [RL5]
        act == psl_pkg::PSL_ACT_STANDBY |=> leds.err_led == leds.run_led)
        else $error("standby error pattern wrong");

    no_err_dark_a: assert property (@(posedge clock) disable iff (reset) // [RL6]
        (!severe && !net_err && act inside {psl_pkg::PSL_ACT_STOP, psl_pkg::PSL_ACT_RUN}) |=> !leds.err_led)
        else $error("error led lit without error");

    bad_node_a: assert property (@(posedge clock) disable iff (reset) // [RL7]
        (wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_START] && !reg_wdata[psl_pkg::PSL_CTRL_RSTX] && prog_valid
         && act == psl_pkg::PSL_ACT_STOP && node_addr == psl_pkg::PSL_NODE_INVALID)
        |=> act == psl_pkg::PSL_ACT_STOP ##1 leds.err_led)
        else $error("invalid node not refused");

    sev_stop_a: assert property (@(posedge clock) disable iff (reset) // [RL8]
        (act == psl_pkg::PSL_ACT_RUN && wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_SEV])
        |=> (act == psl_pkg::PSL_ACT_STOP && cause == psl_pkg::PSL_CAUSE_RUNTIME) ##1 leds.err_led)
        else $error("severe fault did not stop");

    net_clear_a: assert property (@(posedge clock) disable iff (reset) // [RL10]
        (wr_ctrl && reg_wdata[psl_pkg::PSL_CTRL_NETOK] && !reg_wdata[psl_pkg::PSL_CTRL_NETF]
         && act != psl_pkg::PSL_ACT_STOP) |=> !net_err)
        else $error("network error not cleared");

endmodule : psl_status_led

// ---- tb/psl_far_side.sv ----
`timescale 1ns/1ps
// Far side: run/stop switch and the two indicators, watched over a window
module psl_far_side #(
    parameter int WIN = 64
) (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               reset,
    // Switch position asked by the bench, level seen by the block
    input  wire logic               want_run,
    output logic                    switch_run,
    // Indicators and measurement
    input  wire psl_pkg::psl_leds_s leds,
    input  wire logic               meas_go,
    output logic                    meas_done,
    output logic [31:0]             meas
);
    int         left; // Cycles left in the window
    logic [1:0] prev; // Last levels, to spot rising edges
    // Lit cycles and rising edges per LED; a plain count cannot tell quick from slow 1:1
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            switch_run <= 1'b0;
            left       <= 0;
            prev       <= 2'b00;
            meas_done  <= 1'b0;
            meas       <= '0;
        end else begin
            switch_run <= want_run;
            prev       <= {leds.run_led, leds.err_led};
            meas_done  <= (left == 1);
            if (meas_go) begin
                left <= WIN;
                meas <= '0;
            end else if (left > 0) begin
                left        <= left - 1;
                meas[31:24] <= meas[31:24] + 8'(leds.run_led);
                meas[23:16] <= meas[23:16] + 8'(leds.run_led & ~prev[1]);
                meas[15:8]  <= meas[15:8] + 8'(leds.err_led);
                meas[7:0]   <= meas[7:0] + 8'(leds.err_led & ~prev[0]);
            end
        end
    end
endmodule : psl_far_side

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
// Self-checking bench for the status indicator block
module testbench;
    localparam int QD  = 2;          // Short base phase for simulation
    localparam int SM  = 1;          // Slow half period in quick periods
    localparam int WIN = 64;         // Measuring window in cycles
    localparam int QP  = QD * 8;     // Quick period
    localparam int SP  = 2 * SM * QP; // Slow period
    localparam logic [7:0] W = 8'(WIN);
    logic               clock, reset, want_run, switch_run, reg_write, reg_read;
    logic               meas_go, meas_done, rd_d;
    logic [3:0]         reg_addr;
    logic [31:0]        reg_wdata, reg_rdata, meas, node;
    logic [63:0]        e;
    psl_pkg::psl_leds_s leds;
    logic [63:0]        rd_q[$];     // Expected read data with mask
    logic [31:0]        led_q[$];    // Expected LED measurements
    int                 errors, n_compared, cycles;
    // Expected LED patterns {run lit, run rises, err lit, err rises}
    localparam logic [15:0] DARK = 16'h0, STEADY = {W, 8'h0};
    localparam logic [15:0] Q18 = {8'(WIN / 8), 8'(WIN / QP)};
    localparam logic [15:0] Q11 = {8'(WIN / 2), 8'(WIN / QP)};
    localparam logic [15:0] SLOW = {8'(WIN / 2), 8'(WIN / SP)};

    psl_status_led #(.QUICK_DIV(QD), .SLOW_MULT(SM)) dut (.clock(clock), .reset(reset),
        .switch_run(switch_run), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .leds(leds));
    psl_far_side #(.WIN(WIN)) far (.clock(clock), .reset(reset), .want_run(want_run),
        .switch_run(switch_run), .leds(leds), .meas_go(meas_go), .meas_done(meas_done), .meas(meas));

    // 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask : wr

    // Read one register; only the masked bits are judged
    task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
        rd_q.push_back({m, x});
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
    endtask : rd

    // Measure both LEDs over one window after the state has settled
    task automatic look(input string name, input logic [15:0] run, input logic [15:0] err);
        led_q.push_back({run, err});
        repeat (4) @(posedge clock);
        meas_go <= 1'b1;
        @(posedge clock);
        meas_go <= 1'b0;
        for (int i = 0; i < WIN + 8 && !meas_done; i++) @(posedge clock);
        @(posedge clock);
        $display("test %s done", name);
    endtask : look

    function automatic logic [31:0] bit_of(input int unsigned b);
        return 32'h1 << b;
    endfunction : bit_of

    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // Result watcher: read data stands only in the cycle after the strobe
    always @(posedge clock) begin
        rd_d <= reg_read;
        if (rd_d) begin
            e = rd_q.pop_front();
            cmp(reg_rdata & e[63:32], e[31:0]);
        end
        if (meas_done) cmp(meas, led_q.pop_front());
        cycles++;
        if (cycles == 6000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        {reset, want_run, reg_write, reg_read, meas_go, rd_d} = 6'b100000;
        {reg_addr, reg_wdata, errors, n_compared, cycles} = '0;
        void'($urandom(32'h8580708d));
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rd(psl_pkg::PSL_REG_STATUS, 32'h0, 32'hff);
        rd(psl_pkg::PSL_REG_CAUSE, 32'h0, 32'hffffffff);
        rd(4'h2, 32'h0, 32'hffffffff);
        look("after reset", DARK, DARK);
        // Start with node address zero: forced stop, error steady
        wr(psl_pkg::PSL_REG_CTRL, bit_of(psl_pkg::PSL_CTRL_PROG));
        wr(psl_pkg::PSL_REG_CTRL, bit_of(psl_pkg::PSL_CTRL_START));
        rd(psl_pkg::PSL_REG_STATUS, 32'h14, 32'hff);
        rd(psl_pkg::PSL_REG_CAUSE, 32'h1, 32'hffffffff);
        look("config fault", DARK, STEADY);
        node = 32'($urandom_range(255, 1));
        wr(psl_pkg::PSL_REG_NODE, node);
        wr(4'h6, 32'hffffffff);
        rd(psl_pkg::PSL_REG_NODE, node, 32'hff);
        wr(psl_pkg::PSL_REG_CTRL, bit_of(psl_pkg::PSL_CTRL_CLRC));
        rd(psl_pkg::PSL_REG_CAUSE, 32'h0, 32'hffffffff);
        // Start with the switch at stop: standby
        wr(psl_pkg::PSL_REG_CTRL, bit_of(psl_pkg::PSL_CTRL_START));
        rd(psl_pkg::PSL_REG_STATUS, 32'h0d, 32'hff);
        look("standby", Q18, Q18);
        want_run <= 1'b1;
        repeat (3) @(posedge clock);
        rd(psl_pkg::PSL_REG_STATUS, 32'h8e, 32'hff);
        look("run", SLOW, DARK);
        wr(psl_pkg::PSL_REG_CTRL, bit_of(psl_pkg::PSL_CTRL_NETF));
        rd(psl_pkg::PSL_REG_STATUS, 32'hae, 32'hff);
        look("network fault", SLOW, SLOW);
        wr(psl_pkg::PSL_REG_CTRL, bit_of(psl_pkg::PSL_CTRL_NETOK));
        look("network recovered", SLOW, DARK);
        // Runtime fault drops out of run by itself
        wr(psl_pkg::PSL_REG_CTRL, bit_of(psl_pkg::PSL_CTRL_SEV));
        rd(psl_pkg::PSL_REG_STATUS, 32'h94, 32'hff);
        rd(psl_pkg::PSL_REG_CAUSE, 32'h2, 32'hffffffff);
        rd(psl_pkg::PSL_REG_CTRL, 32'h0, 32'hffffffff);
        look("runtime fault", DARK, STEADY);
        wr(psl_pkg::PSL_REG_CTRL, bit_of(psl_pkg::PSL_CTRL_RSTX));
        rd(psl_pkg::PSL_REG_STATUS, 32'h97, 32'hff);
        look("reset mode", Q11, Q11);
        wr(psl_pkg::PSL_REG_CTRL, bit_of(psl_pkg::PSL_CTRL_STOP));
        rd(psl_pkg::PSL_REG_STATUS, 32'h80, 32'hff);
        look("stopped", DARK, DARK);
        // Cause survives the stop and is flagged on the next start
        wr(psl_pkg::PSL_REG_CTRL, bit_of(psl_pkg::PSL_CTRL_PROG));
        wr(psl_pkg::PSL_REG_CTRL, bit_of(psl_pkg::PSL_CTRL_START));
        rd(psl_pkg::PSL_REG_STATUS, 32'hce, 32'hff);
        rd(psl_pkg::PSL_REG_CAUSE, 32'h2, 32'hffffffff);
        // Switch back to stop leaves run on its own
        want_run <= 1'b0;
        repeat (3) @(posedge clock);
        rd(psl_pkg::PSL_REG_STATUS, 32'h44, 32'hff);
        $display("test cause report done");
        wrap_up();
    end
endmodule : testbench
